/* core/lpba_pkg.sv */
// constants and types for the link partner base ability register
package lpba_pkg;
  localparam int unsigned LPBA_WORD_W = 16;
  localparam int unsigned LPBA_ADDR_W = 5;

  typedef logic [LPBA_WORD_W-1:0] lpba_word_t;
  typedef logic [LPBA_ADDR_W-1:0] lpba_addr_t;

  // management address of the register
  localparam lpba_addr_t LPBA_REG_ADDR = 5'h05;

  // value after reset, and the forced-zero masks
  localparam lpba_word_t LPBA_RESET_WORD = 16'h0000;
  localparam lpba_word_t LPBA_RESV_MASK  = 16'h1000;
  localparam lpba_word_t LPBA_NO_MASK    = 16'h0000;

  // field positions
  localparam int unsigned LPBA_NEXT_PAGE_BIT   = 15;
  localparam int unsigned LPBA_ACK_BIT         = 14;
  localparam int unsigned LPBA_REMOTE_FAULT_BIT = 13;
  localparam int unsigned LPBA_RESV_BIT        = 12;
  localparam int unsigned LPBA_ASYM_PAUSE_BIT  = 11;
  localparam int unsigned LPBA_PAUSE_BIT       = 10;
  localparam int unsigned LPBA_FOUR_PAIR_BIT   = 9;
  localparam int unsigned LPBA_HUND_FULL_BIT   = 8;
  localparam int unsigned LPBA_HUND_HALF_BIT   = 7;
  localparam int unsigned LPBA_TEN_FULL_BIT    = 6;
  localparam int unsigned LPBA_TEN_HALF_BIT    = 5;
  localparam int unsigned LPBA_SELECTOR_MSB    = 4;
  localparam int unsigned LPBA_SELECTOR_LSB    = 0;

  // which page the register shows
  typedef enum logic [1:0]
  {
    LPBA_ST_IDLE,
    LPBA_ST_BASE,
    LPBA_ST_NEXT_PAGE
  } lpba_state_t;
endpackage

/* core/lpba_page_reg.sv */
// one received page word, with forced-zero bits and synchronous clear
`timescale 1ns/100ps
`default_nettype none
module lpba_page_reg
#(
  parameter int unsigned               WIDTH     = 16,
  parameter logic [WIDTH-1:0]          ZERO_MASK = '0,
  parameter logic [WIDTH-1:0]          RESET_VAL = '0
)
(
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_clear,
  input  wire logic                    i_load,
  input  wire logic [WIDTH-1:0]        i_data,
  output logic      [WIDTH-1:0]        o_q
);
  logic [WIDTH-1:0] q;
  logic [WIDTH-1:0] next_q;

  always_comb
  begin
    next_q = q;
    if (i_clear)
    begin
      next_q = RESET_VAL;
    end
    else if (i_load)
    begin
      next_q = i_data & ~ZERO_MASK;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      q <= RESET_VAL;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign o_q = q;
endmodule // lpba_page_reg
`default_nettype wire

/* core/lpba_link_partner_base_ability.sv */
// link partner ability register: base page view and next-page view
//
// How it works
// - read-only word at address 0x05, resets zero
// - next-page view after completion with next pages
// - bit 15: partner wants next page exchange
// - bit 14: partner acknowledge, from negotiation
// - bit 13: partner remote fault
// - bit 12 reserved, reads zero in the base view; the next-page view shows it as received
// - bit 11: partner asymmetric pause
// - bit 10: partner symmetric pause
// - bit 9: partner four-pair 100 capability
// - bit 8: partner 100 full duplex
// - bit 7: partner 100 half duplex
// - bit 6: partner 10 full duplex
// - bit 5: partner 10 half duplex
// - bits 4:0 partner selector, reset zero
`timescale 1ns/100ps
`default_nettype none
module lpba_link_partner_base_ability
(
  input  wire logic                    i_clk,
  input  wire logic                    i_reset,
  input  wire logic                    i_an_restart,
  input  wire logic                    i_an_base_valid,
  input  wire lpba_pkg::lpba_word_t    i_an_base_word,
  input  wire logic                    i_an_np_valid,
  input  wire lpba_pkg::lpba_word_t    i_an_np_word,
  input  wire logic                    i_an_complete,
  input  wire logic                    i_local_np_able,
  input  wire lpba_pkg::lpba_addr_t    i_mgmt_addr,
  input  wire logic                    i_mgmt_rd,
  input  wire logic                    i_mgmt_wr,
  output logic                         o_mgmt_rvalid,
  output lpba_pkg::lpba_word_t         o_mgmt_rdata,
  output logic                         o_mgmt_hit,
  output logic                         o_mgmt_wack,
  output logic                         o_np_view,
  output logic                         o_partner_next_page_wish,
  output logic                         o_partner_ack,
  output logic                         o_partner_remote_fault,
  output logic                         o_partner_asym_flow_cap,
  output logic                         o_partner_pause_cap
);
  import lpba_pkg::*;

  function automatic logic lpba_addr_hit(input lpba_addr_t addr);
    lpba_addr_hit = (addr == LPBA_REG_ADDR);
  endfunction

  lpba_word_t  base_q;
  lpba_word_t  np_q;
  lpba_word_t  view;
  lpba_state_t state;
  lpba_state_t next_state;
  logic        np_load;
  logic        base_load;

  // base pages are refused while the next-page view is shown
  assign base_load = i_an_base_valid && (state != LPBA_ST_NEXT_PAGE);

  // base page, filled only by negotiation, never by management
  lpba_page_reg
  #(
    .WIDTH     (LPBA_WORD_W),
    .ZERO_MASK (LPBA_RESV_MASK),
    .RESET_VAL (LPBA_RESET_WORD)
  )
  u_base_page
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (i_an_restart),
    .i_load  (base_load),
    .i_data  (i_an_base_word),
    .o_q     (base_q)
  );

  assign np_load = i_an_np_valid && (state == LPBA_ST_NEXT_PAGE);

  lpba_page_reg
  #(
    .WIDTH     (LPBA_WORD_W),
    .ZERO_MASK (LPBA_NO_MASK),
    .RESET_VAL (LPBA_RESET_WORD)
  )
  u_next_page
  (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (i_an_restart),
    .i_load  (np_load),
    .i_data  (i_an_np_word),
    .o_q     (np_q)
  );

  // view may leave the base page only when both ends want next pages
  function automatic logic lpba_np_switch
  (
    input logic       complete,
    input logic       local_able,
    input lpba_word_t base_word
  );
    lpba_np_switch = complete && local_able && base_word[LPBA_NEXT_PAGE_BIT];
  endfunction

  // page view selection; only a restart or a reset brings the base view back
  always_comb
  begin
    next_state = state;
    case (state)
      LPBA_ST_IDLE:
      begin
        if (i_an_base_valid)
        begin
          next_state = LPBA_ST_BASE;
        end
      end
      LPBA_ST_BASE:
      begin
        if (lpba_np_switch(i_an_complete, i_local_np_able, base_q))
        begin
          next_state = LPBA_ST_NEXT_PAGE;
        end
      end
      LPBA_ST_NEXT_PAGE:
      begin
        next_state = LPBA_ST_NEXT_PAGE;
      end
      default:
      begin
        next_state = LPBA_ST_IDLE;
      end
    endcase
    if (i_an_restart)
    begin
      next_state = LPBA_ST_IDLE;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= LPBA_ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // page shown in each state; reserved bit kept low in the base view
  function automatic lpba_word_t lpba_view_pick
  (
    input lpba_state_t st,
    input lpba_word_t  base_word,
    input lpba_word_t  np_word
  );
    case (st)
      LPBA_ST_NEXT_PAGE:
      begin
        lpba_view_pick = np_word;
      end
      LPBA_ST_IDLE,
      LPBA_ST_BASE:
      begin
        lpba_view_pick = base_word & ~LPBA_RESV_MASK;
      end
      default:
      begin
        lpba_view_pick = LPBA_RESET_WORD;
      end
    endcase
  endfunction

  always_comb
  begin
    view = lpba_view_pick(state, base_q, np_q);
  end

  // management strobes; a write without a read is answered but its data goes nowhere
  logic        next_rvalid;
  logic        next_hit;
  logic        next_wack;

  always_comb
  begin
    next_rvalid = i_mgmt_rd;
    next_hit    = lpba_addr_hit(i_mgmt_addr);
    next_wack   = 1'b0;
    if (i_mgmt_wr && !i_mgmt_rd)
    begin
      next_wack = 1'b1;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_mgmt_rvalid <= 1'b0;
      o_mgmt_hit    <= 1'b0;
      o_mgmt_wack   <= 1'b0;
    end
    else
    begin
      o_mgmt_rvalid <= next_rvalid;
      o_mgmt_hit    <= next_hit;
      o_mgmt_wack   <= next_wack;
    end
  end

  // read data, zero in every cycle without a read of this address
  lpba_word_t  next_rdata;

  always_comb
  begin
    next_rdata = LPBA_RESET_WORD;
    if (i_mgmt_rd && lpba_addr_hit(i_mgmt_addr))
    begin
      next_rdata = view;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_mgmt_rdata <= LPBA_RESET_WORD;
    end
    else
    begin
      o_mgmt_rdata <= next_rdata;
    end
  end

  // view flag, taken from the next state so it moves with the view
  logic        next_np_view;

  always_comb
  begin
    next_np_view = (next_state == LPBA_ST_NEXT_PAGE);
  end

  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      o_np_view <= 1'b0;
    end
    else
    begin
      o_np_view <= next_np_view;
    end
  end

  // partner fields, one flop each, one cycle behind the base page
  localparam int unsigned LPBA_NUM_FLAGS = 5;

  // flag index to base page bit
  function automatic int unsigned lpba_flag_pos(input int unsigned idx);
    case (idx)
      0:       lpba_flag_pos = LPBA_PAUSE_BIT;
      1:       lpba_flag_pos = LPBA_ASYM_PAUSE_BIT;
      2:       lpba_flag_pos = LPBA_REMOTE_FAULT_BIT;
      3:       lpba_flag_pos = LPBA_ACK_BIT;
      4:       lpba_flag_pos = LPBA_NEXT_PAGE_BIT;
      default: lpba_flag_pos = LPBA_RESV_BIT;
    endcase
  endfunction

  for (genvar gi = 0; gi < LPBA_NUM_FLAGS; gi++)
  begin : g_flag
    logic flag;
    logic next_flag;

    // ack comes in with the word, set by the negotiation logic
    always_comb
    begin
      next_flag = base_q[lpba_flag_pos(gi)];
    end

    always_ff @(posedge i_clk)
    begin
      if (i_reset)
      begin
        flag <= 1'b0;
      end
      else
      begin
        flag <= next_flag;
      end
    end
  end

  // field outputs, each straight from its flop
  assign o_partner_pause_cap      = g_flag[0].flag;
  assign o_partner_asym_flow_cap  = g_flag[1].flag;
  assign o_partner_remote_fault   = g_flag[2].flag;
  assign o_partner_ack            = g_flag[3].flag;
  assign o_partner_next_page_wish = g_flag[4].flag;
endmodule // lpba_link_partner_base_ability
`default_nettype wire

/* test/lpba_props.sv */
// port checker for the link partner ability register
`timescale 1ns/100ps
`default_nettype none
module lpba_props
(
  input wire logic                 i_clk,
  input wire logic                 i_reset,
  input wire logic                 i_an_restart,
  input wire logic                 i_an_base_valid,
  input wire lpba_pkg::lpba_word_t i_an_base_word,
  input wire lpba_pkg::lpba_addr_t i_mgmt_addr,
  input wire logic                 i_mgmt_rd,
  input wire logic                 i_mgmt_wr,
  input wire logic                 o_mgmt_rvalid,
  input wire lpba_pkg::lpba_word_t o_mgmt_rdata,
  input wire logic                 o_mgmt_hit,
  input wire logic                 o_mgmt_wack,
  input wire logic                 o_np_view,
  input wire logic                 o_partner_next_page_wish,
  input wire logic                 o_partner_ack,
  input wire logic                 o_partner_remote_fault,
  input wire logic                 o_partner_asym_flow_cap,
  input wire logic                 o_partner_pause_cap
);
  import lpba_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  a_read_answer: assert property (i_mgmt_rd |=> o_mgmt_rvalid)
    else $error("read not answered");
  a_write_ignored: assert property (i_mgmt_wr && !i_mgmt_rd |=> o_mgmt_wack && !o_mgmt_rvalid)
    else $error("write not acked");
  a_resv_zero: assert property (!$past(o_np_view) |-> !o_mgmt_rdata[LPBA_RESV_BIT])
    else $error("reserved bit set");
  a_miss_zero: assert property (i_mgmt_rd && i_mgmt_addr != LPBA_REG_ADDR |=> !o_mgmt_hit && o_mgmt_rdata == '0)
    else $error("other address answered");
  a_hit_addr: assert property (i_mgmt_rd && i_mgmt_addr == LPBA_REG_ADDR |=> o_mgmt_hit)
    else $error("address not hit");
  a_idle_zero: assert property (!i_mgmt_rd |=> o_mgmt_rdata == '0)
    else $error("data without read");
  a_field_copy: assert property (i_an_base_valid && !o_np_view && !i_an_restart ##1 !i_an_restart |=>
    {o_partner_next_page_wish, o_partner_ack, o_partner_remote_fault, o_partner_asym_flow_cap, o_partner_pause_cap}
    == {$past(i_an_base_word[15:13], 2), $past(i_an_base_word[11:10], 2)})
    else $error("field copy wrong");
  a_view_holds: assert property (o_np_view && !i_an_restart |=> o_np_view)
    else $error("view dropped");
  a_restart_base: assert property (i_an_restart |=> !o_np_view)
    else $error("restart kept view");
endmodule // lpba_props
`default_nettype wire

/* test/lpba_partner.sv */
// behavioural remote link partner feeding received pages
`timescale 1ns/100ps
`default_nettype none
module lpba_partner
(
  input  wire logic           i_clk,
  output lpba_pkg::lpba_word_t o_an_base_word,
  output lpba_pkg::lpba_word_t o_an_np_word,
  output logic                o_an_base_valid,
  output logic                o_an_np_valid,
  output logic                o_an_complete
);
  import lpba_pkg::*;
  initial
  begin
    {o_an_base_valid, o_an_np_valid, o_an_complete} = '0;
    {o_an_base_word, o_an_np_word} = '0;
  end
  // one page per burst, word inverted once released
  task page(input logic np, input lpba_word_t w);
    @(posedge i_clk) #2;
    if (np) {o_an_np_valid, o_an_np_word} = {1'b1, w};
    else {o_an_base_valid, o_an_base_word} = {1'b1, w};
    @(posedge i_clk) #2;
    {o_an_base_valid, o_an_np_valid} = '0;
    {o_an_base_word, o_an_np_word} = ~{o_an_base_word, o_an_np_word};
  endtask
  task finish(input logic v);
    o_an_complete = v;
  endtask
endmodule // lpba_partner
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the link partner ability register
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb;
  import lpba_pkg::*;
  logic i_clk = 0, i_reset = 1, i_an_restart = 0, i_an_base_valid, i_an_np_valid, i_an_complete;
  logic i_local_np_able = 0, i_mgmt_rd = 0, i_mgmt_wr = 0;
  logic o_mgmt_rvalid, o_mgmt_hit, o_mgmt_wack, o_np_view, o_partner_next_page_wish;
  logic o_partner_ack, o_partner_remote_fault, o_partner_asym_flow_cap, o_partner_pause_cap;
  lpba_word_t i_an_base_word, i_an_np_word, o_mgmt_rdata, w;
  lpba_addr_t i_mgmt_addr = '0;
  int fails = 0, num_checks = 0;
  always #12.5 i_clk = ~i_clk;
  lpba_link_partner_base_ability uut (.*);
  lpba_partner p (.i_clk, .o_an_base_word(i_an_base_word), .o_an_np_word(i_an_np_word),
    .o_an_base_valid(i_an_base_valid), .o_an_np_valid(i_an_np_valid), .o_an_complete(i_an_complete));
  task acc(input logic wr, input lpba_addr_t a, input lpba_word_t e);
    @(posedge i_clk) #2;
    {i_mgmt_wr, i_mgmt_rd, i_mgmt_addr} = {wr, !wr, a};
    @(posedge i_clk) #2;
    {i_mgmt_wr, i_mgmt_rd, i_mgmt_addr} = {2'b00, ~a};
    `CHK("ack", 1'b1, wr ? o_mgmt_wack : o_mgmt_rvalid)
    `CHK("hit", (a == LPBA_REG_ADDR), o_mgmt_hit)
    if (!wr) `CHK("rdata", e, o_mgmt_rdata)
  endtask
  task summarize;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge i_clk);
    #2 i_reset = 0;
    acc(0, LPBA_REG_ADDR, LPBA_RESET_WORD);
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      w = 16'h0001 << i;
      p.page(0, w);
      acc(0, LPBA_REG_ADDR, w & ~LPBA_RESV_MASK);
      `CHK("fields", {w[15:13], w[11:10]}, {o_partner_next_page_wish, o_partner_ack, o_partner_remote_fault,
        o_partner_asym_flow_cap, o_partner_pause_cap})
    end
    p.page(0, 16'hFFFF);
    acc(1, LPBA_REG_ADDR, '0);
    acc(0, LPBA_REG_ADDR, 16'hEFFF);
    acc(0, 5'h04, 16'h0000);
    $display("test fields done");
    i_local_np_able = 1;
    p.page(0, 16'h8001);
    p.finish(1);
    acc(0, LPBA_REG_ADDR, 16'h0000);
    `CHK("view", 1'b1, o_np_view)
    p.page(0, 16'h0F0F);
    p.page(1, 16'h2345);
    acc(0, LPBA_REG_ADDR, 16'h2345);
    @(posedge i_clk) #2 i_an_restart = 1;
    @(posedge i_clk) #2 i_an_restart = 0;
    p.finish(0);
    `CHK("view", 1'b0, o_np_view)
    acc(0, LPBA_REG_ADDR, 16'h0000);
    $display("test next page done");
    summarize();
  end
  initial
  begin
    #25000;
    fails++;
    summarize();
  end
endmodule // tb
bind lpba_link_partner_base_ability lpba_props chk (.*);
`default_nettype wire
